// File: bench/sfcr_regs_sva.sv
// Assertion checker for the synthesizer frequency registers
`timescale 1ns/1ps
module sfcr_regs_chk (
    input logic        clk,
    input logic        reset_n,
    input logic [8:0]  reg_addr,
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [7:0]  reg_wdata,
    input logic [7:0]  reg_rdata,
    input logic [15:0] synth0_base_frequency_value,
    input logic [15:0] synth0_base_multiplier_value,
    input logic [15:0] synth0_ratio_numerator,
    input logic [15:0] synth0_ratio_denominator,
    input logic [15:0] synth1_base_frequency_value,
    input logic [15:0] synth1_base_multiplier_value,
    input logic [67:0] synth0_freq_hz,
    input logic [67:0] synth1_freq_hz
);
    // ****************************************
    // Checks
    // ****************************************
    function automatic logic [67:0] fx(input logic [15:0] b, m, n, d);
        fx = (d == 16'h0000) ? b * m * 16 * n : b * m * 16 * n / d;
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_pair(a);
        reg_wr && reg_addr == a ##1 reg_wr && reg_addr == a + 9'h001;
    endsequence
    property p_pair(a, v);
        s_pair(a) |=> v == {$past(reg_wdata, 2), $past(reg_wdata)};
    endproperty
    AST_S0_MULT: assert property (p_pair(9'h1BA, synth0_base_multiplier_value))
        else $error("Multiplier commit wrong");
    AST_S1_BASE: assert property (p_pair(9'h1C0, synth1_base_frequency_value))
        else $error("Synth1 base commit wrong");
    AST_S1_MULT: assert property (p_pair(9'h1C2, synth1_base_multiplier_value))
        else $error("Synth1 multiple commit wrong");
    AST_RATIO: assert property (s_pair(9'h1BC) ##1 s_pair(9'h1BE) |=>
        {synth0_ratio_numerator, synth0_ratio_denominator} ==
        {$past(reg_wdata, 4), $past(reg_wdata, 3), $past(reg_wdata, 2), $past(reg_wdata)})
        else $error("Ratio commit wrong");
    AST_MSB_HOLD: assert property (reg_wr && reg_addr == 9'h1BA |=> $stable(synth0_base_multiplier_value))
        else $error("Upper byte changed output");
    AST_FREQ0: assert property ($past(reset_n) |-> synth0_freq_hz == fx($past(synth0_base_frequency_value),
        $past(synth0_base_multiplier_value), $past(synth0_ratio_numerator), $past(synth0_ratio_denominator)))
        else $error("Synth0 frequency wrong");
    AST_FREQ1: assert property ($past(reset_n) |-> synth1_freq_hz == fx($past(synth1_base_frequency_value),
        $past(synth1_base_multiplier_value), 16'h0001, 16'h0001))
        else $error("Synth1 frequency wrong");
    AST_RD: assert property (reg_rd && !reg_wr && reg_addr == 9'h1BA |=>
        reg_rdata == $past(synth0_base_multiplier_value[15:8]))
        else $error("Read byte wrong");
endmodule
bind sfcr_regs sfcr_regs_chk u_chk (
    .clk                          (clk),
    .reset_n                      (reset_n),
    .reg_addr                     (reg_addr),
    .reg_wr                       (reg_wr),
    .reg_rd                       (reg_rd),
    .reg_wdata                    (reg_wdata),
    .reg_rdata                    (reg_rdata),
    .synth0_base_frequency_value  (synth0_base_frequency_value),
    .synth0_base_multiplier_value (synth0_base_multiplier_value),
    .synth0_ratio_numerator       (synth0_ratio_numerator),
    .synth0_ratio_denominator     (synth0_ratio_denominator),
    .synth1_base_frequency_value  (synth1_base_frequency_value),
    .synth1_base_multiplier_value (synth1_base_multiplier_value),
    .synth0_freq_hz               (synth0_freq_hz),
    .synth1_freq_hz               (synth1_freq_hz)
);

// File: bench/sfcr_regs_tb_top.sv
// Testbench for the synthesizer frequency registers
`timescale 1ns/1ps
module sfcr_regs_tb_top;
    typedef struct {logic [8:0] a; int n; int k; logic [31:0] v;} sfcr_row_t;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [8:0]  reg_addr = 9'h000;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [15:0] synth0_base_frequency_value = 16'h9C40;
    logic [15:0] synth0_base_multiplier_value, synth0_ratio_numerator, synth0_ratio_denominator;
    logic [15:0] synth1_base_frequency_value, synth1_base_multiplier_value;
    logic [67:0] synth0_freq_hz, synth1_freq_hz;
    logic [15:0] e[5];
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;
    // Rows keep every synthesizer between 1 and 1.5 GHz, clear of the forbidden multiples
    sfcr_row_t   rows[6] = '{'{9'h1BA, 2, 0, 32'h000007D0}, '{9'h1BC, 4, 1, 32'h00FF00ED},
        '{9'h1C2, 2, 4, 32'h00000C80}, '{9'h1C0, 2, 3, 32'h00004E20},
        '{9'h1BC, 4, 1, 32'h41BE3B80}, '{9'h1BC, 4, 1, 32'h00010001}};
    sfcr_regs i_dut (
        .clk                          (clk),
        .reset_n                      (reset_n),
        .reg_addr                     (reg_addr),
        .reg_wr                       (reg_wr),
        .reg_rd                       (reg_rd),
        .reg_wdata                    (reg_wdata),
        .reg_rdata                    (reg_rdata),
        .synth0_base_frequency_value  (synth0_base_frequency_value),
        .synth0_base_multiplier_value (synth0_base_multiplier_value),
        .synth0_ratio_numerator       (synth0_ratio_numerator),
        .synth0_ratio_denominator     (synth0_ratio_denominator),
        .synth1_base_frequency_value  (synth1_base_frequency_value),
        .synth1_base_multiplier_value (synth1_base_multiplier_value),
        .synth0_freq_hz               (synth0_freq_hz),
        .synth1_freq_hz               (synth1_freq_hz)
    );
    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [67:0] fx(input logic [15:0] b, m, n, d);
        fx = (d == 16'h0000) ? b * m * 16 * n : b * m * 16 * n / d;
    endfunction
    task automatic chk(input logic [67:0] g, x);
        total_checks++;
        if (g !== x) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic bus(input logic w, r, input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic idle(input int c);
        repeat (c) bus(1'b0, 1'b0, 9'h000, 8'h00);
        #1;
    endtask
    task automatic get(input logic [8:0] a, input logic [7:0] x);
        bus(1'b0, 1'b1, a, 8'h00);
        idle(1);
        chk(reg_rdata, x);
    endtask
    task automatic check_all;
        chk(synth0_base_multiplier_value, e[0]);
        chk(synth0_ratio_numerator, e[1]);
        chk(synth0_ratio_denominator, e[2]);
        chk(synth1_base_frequency_value, e[3]);
        chk(synth1_base_multiplier_value, e[4]);
        chk(synth0_freq_hz, fx(synth0_base_frequency_value, e[0], e[1], e[2]));
        chk(synth1_freq_hz, fx(e[3], e[4], 16'h0001, 16'h0001));
    endtask
    task automatic complete_run;
        $display("Checks %0d, failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // Stimulus
    // ****************************************
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            complete_run;
        end
    end
    initial begin
        e = '{16'h0798, 16'h0001, 16'h0001, 16'h61A8, 16'h0C35};
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        idle(2);
        foreach (rows[r]) begin
            for (int i = 0; i < rows[r].n; i++)
                bus(1'b1, 1'b0, rows[r].a + 9'(i), 8'(rows[r].v >> (8 * (rows[r].n - 1 - i))));
            idle(3);
            if (rows[r].n == 4) begin
                e[1] = rows[r].v[31:16];
                e[2] = rows[r].v[15:0];
            end else
                e[rows[r].k] = rows[r].v[15:0];
            check_all;
            for (int i = 0; i < rows[r].n; i++)
                get(rows[r].a + 9'(i), 8'(rows[r].v >> (8 * (rows[r].n - 1 - i))));
        end
        bus(1'b1, 1'b0, 9'h1BA, 8'h08);
        idle(3);
        check_all;
        bus(1'b1, 1'b0, 9'h1BB, 8'h34);
        idle(3);
        e[0] = 16'h0834;
        check_all;
        // Zero denominator leaves the product undivided
        for (int i = 0; i < 4; i++)
            bus(1'b1, 1'b0, 9'h1BC + 9'(i), 8'(32'h00010000 >> (8 * (3 - i))));
        idle(3);
        e[1] = 16'h0001;
        e[2] = 16'h0000;
        check_all;
        get(9'h1B0, 8'h00);
        get(9'h1BA, 8'h08);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        e = '{16'h0798, 16'h0001, 16'h0001, 16'h61A8, 16'h0C35};
        idle(2);
        chk(reg_rdata, 8'h00);
        check_all;
        complete_run;
    end
endmodule

// File: src/sfcr_freq_calc.v
// Synthesizer frequency arithmetic: base times multiple times 16 times numerator, divided by the denominator unless it is zero
`timescale 1ns/1ps
`include "sfcr_map.vh"

module sfcr_freq_calc (
    clk,
    reset_n,
    base_frequency_value,
    base_multiplier_value,
    ratio_numerator,
    ratio_denominator,
    synth_freq_hz
);
    input  wire        clk;
    input  wire        reset_n;
    input  wire [15:0] base_frequency_value;
    input  wire [15:0] base_multiplier_value;
    input  wire [15:0] ratio_numerator;
    input  wire [15:0] ratio_denominator;
    output reg  [67:0] synth_freq_hz;

    reg  [67:0] product_w;
    reg  [67:0] freq_nxt;

    // ****************************************
    // Frequency computation
    // ****************************************
    always @* begin
        product_w = {52'h0, base_frequency_value} * {52'h0, base_multiplier_value}; // RULE2
        product_w = {product_w[63:0], 4'h0}; // RULE2
        product_w = product_w * {52'h0, ratio_numerator}; // RULE5
        if (ratio_denominator == 16'h0000) begin
            freq_nxt = product_w;
        end else begin
            freq_nxt = product_w / {52'h0, ratio_denominator}; // RULE5
        end
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            synth_freq_hz <= 68'h0;
        end else begin
            synth_freq_hz <= freq_nxt;
        end
    end
endmodule

// File: src/sfcr_map.vh
// Register offsets, reset values and field positions of the synthesizer frequency registers
`ifndef SFCR_MAP_VH
`define SFCR_MAP_VH

// ****************************************
// Byte addresses (big endian, MSB at lowest)
// ****************************************
`define SFCR_ADDR_S0_MULT     9'h1BA
`define SFCR_ADDR_S0_RATIO    9'h1BC
`define SFCR_ADDR_S1_BASE     9'h1C0
`define SFCR_ADDR_S1_MULT     9'h1C2

// ****************************************
// Reset values
// ****************************************
`define SFCR_RST_S0_MULT      16'h0798
`define SFCR_RST_S0_RATIO     32'h00010001
`define SFCR_RST_S0_NUM       16'h0001
`define SFCR_RST_S0_DEN       16'h0001
`define SFCR_RST_S1_BASE      16'h61A8
`define SFCR_RST_S1_MULT      16'h0C35
`define SFCR_RST_S0_BASE      16'h9C40

// ****************************************
// Field positions
// ****************************************
`define SFCR_NUM_MSB          31
`define SFCR_NUM_LSB          16
`define SFCR_DEN_MSB          15
`define SFCR_DEN_LSB          0
`define SFCR_FREQ_SCALE       6'h10

`endif

// File: src/sfcr_regs.v
// Synthesizer 0/1 frequency configuration registers with byte-wide big-endian access
//
// Rules for this block and for the software that drives it
// RULE1 - Synth0 multiple is 16-bit unsigned, bits 15:0
// RULE2 - Plain frequency equals base times multiple times 16
// RULE3 - Software keeps frequency within 1 to 1.5 GHz
// RULE4 - Software avoids multiples of listed forbidden frequencies
// RULE5 - FEC frequency scaled by numerator over denominator
// RULE6 - Ratio register: numerator 31:16, denominator 15:0
// RULE7 - Software writes one/one when no FEC
// RULE8 - Software base value divides 1600000000 exactly
// RULE9 - Synth1 base read like synth0 base
// RULE10 - Multi-byte writes MSB first, LSB last
// RULE11 - Apply value only after final LSB write
`timescale 1ns/1ps
`include "sfcr_map.vh"

module sfcr_regs (
    clk,
    reset_n,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata,
    synth0_base_frequency_value,
    synth0_base_multiplier_value,
    synth0_ratio_numerator,
    synth0_ratio_denominator,
    synth1_base_frequency_value,
    synth1_base_multiplier_value,
    synth0_freq_hz,
    synth1_freq_hz
);
    input  wire        clk;
    input  wire        reset_n;
    input  wire [8:0]  reg_addr;
    input  wire        reg_wr;
    input  wire        reg_rd;
    input  wire [7:0]  reg_wdata;
    output reg  [7:0]  reg_rdata;
    input  wire [15:0] synth0_base_frequency_value;
    output reg  [15:0] synth0_base_multiplier_value;
    output reg  [15:0] synth0_ratio_numerator;
    output reg  [15:0] synth0_ratio_denominator;
    output reg  [15:0] synth1_base_frequency_value;
    output reg  [15:0] synth1_base_multiplier_value;
    output wire [67:0] synth0_freq_hz;
    output wire [67:0] synth1_freq_hz;

    // ****************************************
    // Staging (upper bytes) and write strobes
    // ****************************************
    reg [7:0]  s0_mult_stage_r;
    reg [31:8] s0_ratio_stage_r;
    reg [7:0]  s1_base_stage_r;
    reg [7:0]  s1_mult_stage_r;
    reg [7:0]  rdata_nxt;
    wire       s0_mult_l0_wr;
    wire       s0_mult_l1_wr;
    wire       s0_ratio_l0_wr;
    wire       s0_ratio_l1_wr;
    wire       s0_ratio_l2_wr;
    wire       s0_ratio_l3_wr;
    wire       s1_base_l0_wr;
    wire       s1_base_l1_wr;
    wire       s1_mult_l0_wr;
    wire       s1_mult_l1_wr;

    // Byte lane of a big-endian multi-byte register
    function [7:0] sfcr_be_byte;
        input [31:0] value;
        input [1:0]  lane;
        input [1:0]  last;
        reg   [1:0]  shift;
        reg   [31:0] shifted;
        begin
            shift = last - lane;
            shifted = value >> {shift, 3'h0}; // RULE10
            sfcr_be_byte = shifted[7:0];
        end
    endfunction

    // Write strobe for one byte lane of a register
    function sfcr_wr_hit;
        input       wr;
        input [8:0] addr;
        input [8:0] base;
        input [1:0] lane;
        begin
            sfcr_wr_hit = wr && (addr == (base + {7'h00, lane}));
        end
    endfunction

    // Upper byte of a 16-bit value
    function [7:0] sfcr_hi_byte;
        input [15:0] value;
        begin
            sfcr_hi_byte = value[15:8];
        end
    endfunction

    // Upper three bytes of a 32-bit value
    function [23:0] sfcr_top_bytes;
        input [31:0] value;
        begin
            sfcr_top_bytes = value[31:8];
        end
    endfunction

    // ****************************************
    // Writes: decode, stage bytes, commit on LSB
    // ****************************************
    assign s0_mult_l0_wr  = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S0_MULT, 2'h0);
    assign s0_mult_l1_wr  = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S0_MULT, 2'h1);
    assign s0_ratio_l0_wr = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S0_RATIO, 2'h0);
    assign s0_ratio_l1_wr = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S0_RATIO, 2'h1);
    assign s0_ratio_l2_wr = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S0_RATIO, 2'h2);
    assign s0_ratio_l3_wr = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S0_RATIO, 2'h3);
    assign s1_base_l0_wr  = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S1_BASE, 2'h0);
    assign s1_base_l1_wr  = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S1_BASE, 2'h1);
    assign s1_mult_l0_wr  = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S1_MULT, 2'h0);
    assign s1_mult_l1_wr  = sfcr_wr_hit(reg_wr, reg_addr, `SFCR_ADDR_S1_MULT, 2'h1);

    always @(posedge clk) begin
        if (!reset_n) begin
            s0_mult_stage_r              <= sfcr_hi_byte(`SFCR_RST_S0_MULT);
            s0_ratio_stage_r             <= sfcr_top_bytes(`SFCR_RST_S0_RATIO);
            s1_base_stage_r              <= sfcr_hi_byte(`SFCR_RST_S1_BASE);
            s1_mult_stage_r              <= sfcr_hi_byte(`SFCR_RST_S1_MULT);
            synth0_base_multiplier_value <= `SFCR_RST_S0_MULT;
            synth0_ratio_numerator       <= `SFCR_RST_S0_NUM;
            synth0_ratio_denominator     <= `SFCR_RST_S0_DEN;
            synth1_base_frequency_value  <= `SFCR_RST_S1_BASE;
            synth1_base_multiplier_value <= `SFCR_RST_S1_MULT;
        end else begin
            if (s0_mult_l0_wr) begin
                s0_mult_stage_r <= reg_wdata; // RULE10
            end
            if (s0_mult_l1_wr) begin
                synth0_base_multiplier_value <= {s0_mult_stage_r, reg_wdata}; // RULE1 RULE11
            end
            if (s0_ratio_l0_wr) begin
                s0_ratio_stage_r[31:24] <= reg_wdata; // RULE10
            end
            if (s0_ratio_l1_wr) begin
                s0_ratio_stage_r[23:16] <= reg_wdata;
            end
            if (s0_ratio_l2_wr) begin
                s0_ratio_stage_r[15:8] <= reg_wdata;
            end
            if (s0_ratio_l3_wr) begin
                synth0_ratio_numerator   <= s0_ratio_stage_r[`SFCR_NUM_MSB:`SFCR_NUM_LSB]; // RULE6 RULE11
                synth0_ratio_denominator <= {s0_ratio_stage_r[`SFCR_DEN_MSB:8], reg_wdata}; // RULE6 RULE11
            end
            if (s1_base_l0_wr) begin
                s1_base_stage_r <= reg_wdata; // RULE10
            end
            if (s1_base_l1_wr) begin
                synth1_base_frequency_value <= {s1_base_stage_r, reg_wdata}; // RULE9 RULE11
            end
            if (s1_mult_l0_wr) begin
                s1_mult_stage_r <= reg_wdata; // RULE10
            end
            if (s1_mult_l1_wr) begin
                synth1_base_multiplier_value <= {s1_mult_stage_r, reg_wdata}; // RULE11
            end
        end
    end

    // ****************************************
    // Reads: live (applied) values
    // ****************************************
    always @* begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `SFCR_ADDR_S0_MULT:          rdata_nxt = sfcr_be_byte({16'h0, synth0_base_multiplier_value}, 2'h0, 2'h1);
            `SFCR_ADDR_S0_MULT + 9'h001: rdata_nxt = sfcr_be_byte({16'h0, synth0_base_multiplier_value}, 2'h1, 2'h1);
            `SFCR_ADDR_S0_RATIO:
                rdata_nxt = sfcr_be_byte({synth0_ratio_numerator, synth0_ratio_denominator}, 2'h0, 2'h3);
            `SFCR_ADDR_S0_RATIO + 9'h001:
                rdata_nxt = sfcr_be_byte({synth0_ratio_numerator, synth0_ratio_denominator}, 2'h1, 2'h3);
            `SFCR_ADDR_S0_RATIO + 9'h002:
                rdata_nxt = sfcr_be_byte({synth0_ratio_numerator, synth0_ratio_denominator}, 2'h2, 2'h3);
            `SFCR_ADDR_S0_RATIO + 9'h003:
                rdata_nxt = sfcr_be_byte({synth0_ratio_numerator, synth0_ratio_denominator}, 2'h3, 2'h3);
            `SFCR_ADDR_S1_BASE:          rdata_nxt = sfcr_be_byte({16'h0, synth1_base_frequency_value}, 2'h0, 2'h1);
            `SFCR_ADDR_S1_BASE + 9'h001: rdata_nxt = sfcr_be_byte({16'h0, synth1_base_frequency_value}, 2'h1, 2'h1);
            `SFCR_ADDR_S1_MULT:          rdata_nxt = sfcr_be_byte({16'h0, synth1_base_multiplier_value}, 2'h0, 2'h1);
            `SFCR_ADDR_S1_MULT + 9'h001: rdata_nxt = sfcr_be_byte({16'h0, synth1_base_multiplier_value}, 2'h1, 2'h1);
            default:                     rdata_nxt = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

    // ****************************************
    // Frequency results
    // ****************************************
    sfcr_freq_calc u_calc0 (
        .clk                   (clk),
        .reset_n               (reset_n),
        .base_frequency_value  (synth0_base_frequency_value),
        .base_multiplier_value (synth0_base_multiplier_value),
        .ratio_numerator       (synth0_ratio_numerator),
        .ratio_denominator     (synth0_ratio_denominator),
        .synth_freq_hz         (synth0_freq_hz)
    );

    sfcr_freq_calc u_calc1 (
        .clk                   (clk),
        .reset_n               (reset_n),
        .base_frequency_value  (synth1_base_frequency_value),
        .base_multiplier_value (synth1_base_multiplier_value),
        .ratio_numerator       (16'h0001),
        .ratio_denominator     (16'h0001),
        .synth_freq_hz         (synth1_freq_hz)
    );
endmodule
